/* gci_cmd_core.sv */
// module: monitor channel command interpreter for line bits, masks and coefficient transfers
// Functional notes
// RL1 - commands e8 write, e9 read ground-key interval; command bit 0 selects read
// RL2 - four-bit interval 0-15 ms sets sampling period of the second line bit
// RL3 - controller writes upper interval bits as zero, never trusts their readback
// RL4 - reset clears the interval field to zero
// RL5 - 4d reads line bits keeping interrupt; 4f reads and clears it
// RL6 - one byte, two bits per channel, first bit low, channel 1 at bits 1-0
// RL7 - upper bit is second line input, or muxed hook bit when e1 mux enabled
// RL8 - same line bits also go to upstream c/i field
// RL9 - commands 6c write, 6d read the mask; command bit 0 selects read
// RL10 - one mask bit per line bit; only unmasked changes pull interrupt low
// RL11 - reset sets all eight mask bits to one
// RL12 - coefficient write carries 1 to 14 signed-digit data bytes loaded to store
// RL13 - coefficient read returns up to 14 signed-digit bytes upstream
// RL14 - upstream coefficient reply holds data bytes only, no command echo
// RL15 - downstream order is channel address, then command, then write data
// RL16 - coefficient read reaches every stored location for diagnostics
// RL17 - all commands and data travel on the monitor channel, not c/i
// RL18 - debounced first bit changes only after input stable for debounce period
// RL19 - interrupt stays low after unmasked change until a clearing read
`timescale 1ns/1ns
module gci_cmd_core #(
	parameter int MS_CYCLES = gci_pkg::MS_CYCLES,
	parameter int COEF_MAX = gci_pkg::COEF_MAX_BYTES
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic mon_rx_valid_i,
	input wire logic [7:0] mon_rx_byte_i,
	input wire logic mon_rx_last_i,
	output logic mon_rx_ready_o,
	output logic mon_tx_valid_o,
	output logic [7:0] mon_tx_byte_o,
	output logic mon_tx_last_o,
	input wire logic mon_tx_ready_i,
	input wire logic [3:0] line_input_one_i,
	input wire logic [3:0] line_input_two_i,
	input wire logic [3:0] muxed_hook_bit_i,
	input wire logic e1_mux_enable_i,
	input wire logic [3:0] debounce_ms_i,
	output logic [7:0] ci_upstream_o,
	output logic coef_update_o,
	output logic int_b_o
);
	localparam int MSW = $clog2(MS_CYCLES + 1);
	localparam logic [3:0] COEF_LAST = 4'(COEF_MAX - 1);

	function automatic logic is_sop(input logic [7:0] c);
		is_sop = (c == gci_pkg::CMD_GK_WR) || (c == gci_pkg::CMD_GK_RD) ||
			(c == gci_pkg::CMD_RT_RD) || (c == gci_pkg::CMD_RT_RD_CLR) ||
			(c == gci_pkg::CMD_MASK_WR) || (c == gci_pkg::CMD_MASK_RD);
	endfunction

	// ========================================
	// pin synchronisers
	logic [3:0] one_s1_q, one_s2_q, two_s1_q, two_s2_q, mux_s1_q, mux_s2_q;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			one_s1_q <= 4'h0;
			one_s2_q <= 4'h0;
			two_s1_q <= 4'h0;
			two_s2_q <= 4'h0;
			mux_s1_q <= 4'h0;
			mux_s2_q <= 4'h0;
		end else begin
			one_s1_q <= line_input_one_i;
			one_s2_q <= one_s1_q;
			two_s1_q <= line_input_two_i;
			two_s2_q <= two_s1_q;
			mux_s1_q <= muxed_hook_bit_i;
			mux_s2_q <= mux_s1_q;
		end
	end

	// ========================================
	// millisecond enable
	logic [MSW-1:0] ms_cnt_q;
	logic ms_tick;
	assign ms_tick = (ms_cnt_q == MSW'(MS_CYCLES - 1));
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ms_cnt_q <= '0;
		end else if (ms_tick) begin
			ms_cnt_q <= '0;
		end else begin
			ms_cnt_q <= ms_cnt_q + 1'b1;
		end
	end

	// ========================================
	// debounce of the first line bit
	logic [3:0] db_q;
	logic [3:0][3:0] db_cnt_q;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			db_q <= 4'h0;
			db_cnt_q <= '0;
		end else begin
			for (int i = 0; i < gci_pkg::CHANNELS; i++) begin
				if (one_s2_q[i] == db_q[i]) begin
					db_cnt_q[i] <= 4'h0;
				end else if (db_cnt_q[i] >= debounce_ms_i) begin
					db_q[i] <= one_s2_q[i]; // RL18
					db_cnt_q[i] <= 4'h0;
				end else if (ms_tick) begin
					db_cnt_q[i] <= db_cnt_q[i] + 4'h1; // RL18
				end
			end
		end
	end

	// ========================================
	// sampling of the second line bit
	logic [3:0] gk_q;
	logic [3:0] gk_cnt_q;
	logic [3:0] sec_q;
	logic [3:0] sec_src;
	logic gk_strobe;
	assign sec_src = e1_mux_enable_i ? mux_s2_q : two_s2_q; // RL7
	assign gk_strobe = (gk_q == 4'h0) || (ms_tick && (gk_cnt_q >= gk_q - 4'h1)); // RL2
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			gk_cnt_q <= 4'h0;
			sec_q <= 4'h0;
		end else if (gk_strobe) begin
			gk_cnt_q <= 4'h0;
			sec_q <= sec_src; // RL2
		end else if (ms_tick) begin
			gk_cnt_q <= gk_cnt_q + 4'h1;
		end
	end

	// ========================================
	// real-time byte and upstream c/i copy
	logic [7:0] rt;
	always_comb begin
		rt = 8'h00;
		for (int i = 0; i < gci_pkg::CHANNELS; i++) begin
			rt[2*i] = db_q[i]; // RL6
			rt[2*i+1] = sec_q[i]; // RL6 RL7
		end
	end

	logic [7:0] ci_q;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ci_q <= 8'h00;
		end else begin
			ci_q <= rt; // RL8
		end
	end
	assign ci_upstream_o = ci_q;

	// ========================================
	// transfer state machine
	gci_pkg::gci_state_type state_q;
	logic [1:0] chan_q;
	logic [7:0] cmd_q;
	logic [3:0] idx_q;
	logic [3:0] last_idx_q;
	logic tx_valid_q, tx_last_q, upd_q;
	logic [7:0] tx_byte_q;
	logic rx_take, in_cmd, in_data, rt_clr, gk_wr, mask_wr, cop_wr;
	logic [7:0] mask_q;
	logic [7:0] sop_rd;
	gci_ram_if #(.AW(gci_pkg::RAM_AW), .DW(8)) ram ();

	assign mon_rx_ready_o = (state_q == gci_pkg::ST_ADDR) || in_cmd || in_data; // RL17
	assign rx_take = mon_rx_valid_i && mon_rx_ready_o;
	assign in_cmd = (state_q == gci_pkg::ST_CMD);
	assign in_data = (state_q == gci_pkg::ST_DATA);
	assign rt_clr = in_cmd && rx_take && (mon_rx_byte_i == gci_pkg::CMD_RT_RD_CLR) &&
		mon_rx_byte_i[gci_pkg::CMD_CLR_BIT]; // RL5
	assign gk_wr = in_data && rx_take && (cmd_q == gci_pkg::CMD_GK_WR); // RL1
	assign mask_wr = in_data && rx_take && (cmd_q == gci_pkg::CMD_MASK_WR); // RL9
	assign cop_wr = in_data && rx_take && !is_sop(cmd_q) && (idx_q <= COEF_LAST); // RL12

	always_comb begin
		case (mon_rx_byte_i)
			gci_pkg::CMD_GK_RD: sop_rd = {gci_pkg::GK_RSVD_READ, gk_q}; // RL1
			gci_pkg::CMD_MASK_RD: sop_rd = mask_q; // RL9
			default: sop_rd = rt; // RL5 RL6
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= gci_pkg::ST_ADDR;
			chan_q <= 2'h0;
			cmd_q <= 8'h00;
			idx_q <= 4'h0;
			last_idx_q <= 4'h0;
			tx_valid_q <= 1'b0;
			tx_last_q <= 1'b0;
			tx_byte_q <= 8'h00;
			upd_q <= 1'b0;
		end else begin
			upd_q <= 1'b0;
			case (state_q)
				gci_pkg::ST_ADDR: begin
					if (rx_take) begin
						chan_q <= mon_rx_byte_i[gci_pkg::CHAN_W-1:0]; // RL15
						if (!mon_rx_last_i) begin
							state_q <= gci_pkg::ST_CMD;
						end
					end
				end
				gci_pkg::ST_CMD: begin
					if (rx_take) begin
						cmd_q <= mon_rx_byte_i;
						idx_q <= 4'h0;
						if (!mon_rx_byte_i[gci_pkg::CMD_RW_BIT]) begin
							state_q <= mon_rx_last_i ? gci_pkg::ST_ADDR : gci_pkg::ST_DATA; // RL15
						end else if (is_sop(mon_rx_byte_i)) begin
							tx_byte_q <= sop_rd;
							tx_valid_q <= 1'b1;
							tx_last_q <= 1'b1;
							state_q <= gci_pkg::ST_SEND;
						end else begin
							last_idx_q <= COEF_LAST; // RL13
							state_q <= gci_pkg::ST_FETCH;
						end
					end
				end
				gci_pkg::ST_DATA: begin
					if (rx_take) begin
						if (idx_q <= COEF_LAST) begin
							idx_q <= idx_q + 4'h1;
						end
						if (mon_rx_last_i) begin
							upd_q <= !is_sop(cmd_q); // RL12
							state_q <= gci_pkg::ST_ADDR;
						end
					end
				end
				gci_pkg::ST_FETCH: begin
					state_q <= gci_pkg::ST_LOAD;
				end
				gci_pkg::ST_LOAD: begin
					tx_byte_q <= ram.rdata; // RL14 RL16
					tx_valid_q <= 1'b1;
					tx_last_q <= (idx_q == last_idx_q);
					state_q <= gci_pkg::ST_SEND;
				end
				gci_pkg::ST_SEND: begin
					if (mon_tx_ready_i) begin
						tx_valid_q <= 1'b0;
						tx_last_q <= 1'b0;
						if (tx_last_q) begin
							state_q <= gci_pkg::ST_ADDR;
						end else begin
							idx_q <= idx_q + 4'h1;
							state_q <= gci_pkg::ST_FETCH;
						end
					end
				end
				default: begin
					state_q <= gci_pkg::ST_ADDR;
				end
			endcase
		end
	end

	assign mon_tx_valid_o = tx_valid_q;
	assign mon_tx_byte_o = tx_byte_q;
	assign mon_tx_last_o = tx_last_q;
	assign coef_update_o = upd_q;

	// ========================================
	// coefficient store
	assign ram.we = cop_wr;
	assign ram.re = (state_q == gci_pkg::ST_FETCH);
	assign ram.addr = {chan_q, cmd_q[gci_pkg::SLOT_LSB +: gci_pkg::SLOT_W], idx_q}; // RL16
	assign ram.wdata = mon_rx_byte_i;

	gci_coef_ram #(.AW(gci_pkg::RAM_AW), .DW(8)) u_ram (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.ram(ram.mem)
	);

	// ========================================
	// interval and mask registers
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			gk_q <= gci_pkg::GK_RESET; // RL4
		end else if (gk_wr) begin
			gk_q <= mon_rx_byte_i[gci_pkg::GK_LSB +: gci_pkg::GK_W]; // RL2
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mask_q <= gci_pkg::MASK_RESET; // RL11
		end else if (mask_wr) begin
			mask_q <= mon_rx_byte_i; // RL9
		end
	end

	// ========================================
	// interrupt
	logic [7:0] rt_prev_q;
	logic rt_event, irq_q;
	assign rt_event = |((rt ^ rt_prev_q) & ~mask_q); // RL10
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rt_prev_q <= 8'h00;
			irq_q <= 1'b0;
		end else begin
			rt_prev_q <= rt;
			if (rt_event) begin
				irq_q <= 1'b1; // RL10 RL19
			end else if (rt_clr) begin
				irq_q <= 1'b0; // RL5
			end
		end
	end
	assign int_b_o = !irq_q;

	// ========================================
	// checks
	a_gk_write: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL1
		gk_wr |=> gk_q == $past(mon_rx_byte_i[3:0])) else $error("interval not written");
	a_gk_sample: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL2
		!gk_strobe |=> sec_q == $past(sec_q)) else $error("second bit moved between samples");
	a_gk_reset: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL4
		$rose(rst_b_i) |-> gk_q == 4'h0) else $error("interval not cleared by reset");
	a_rt_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL5
		rt_clr && !rt_event |=> int_b_o) else $error("clearing read left interrupt");
	a_rt_keep: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL5
		in_cmd && rx_take && mon_rx_byte_i == 8'h4d && !int_b_o |=> !int_b_o)
		else $error("plain read cleared interrupt");
	a_rt_reply: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL6
		in_cmd && rx_take && mon_rx_byte_i == 8'h4d |=> mon_tx_valid_o && mon_tx_last_o &&
		mon_tx_byte_o == $past(rt)) else $error("real-time reply wrong");
	a_ci_mirror: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL8
		1'b1 |=> ci_upstream_o == $past(rt)) else $error("c/i copy wrong");
	a_mask_reset: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL11
		$rose(rst_b_i) |-> mask_q == 8'hff) else $error("mask not set by reset");
	a_masked_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL10
		int_b_o && !rt_event |=> int_b_o) else $error("interrupt without unmasked change");
	a_irq_hold: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL19
		rt_event |=> !int_b_o ##1 (!int_b_o || $past(rt_clr))) else $error("interrupt dropped");
	a_cop_len: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL13
		(state_q == gci_pkg::ST_SEND) && !is_sop(cmd_q) |-> idx_q <= 4'hd)
		else $error("coefficient reply too long");
	a_cop_first: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL14
		in_cmd && rx_take && mon_rx_byte_i[0] && !is_sop(mon_rx_byte_i) |=>
		!mon_tx_valid_o ##1 !mon_tx_valid_o ##1 mon_tx_valid_o && idx_q == 4'h0)
		else $error("coefficient reply timing wrong");
	a_db_stable: assert property (@(posedge clk_i) disable iff (!rst_b_i) // RL18
		debounce_ms_i != 4'h0 && $changed(db_q) |-> $past(db_cnt_q) != '0)
		else $error("debounce skipped");
endmodule

/* gci_pkg.sv */
// package: command codes, reset values, field layout and timing for the gci command block
package gci_pkg;
	// ========================================
	// monitor channel command codes
	localparam logic [7:0] CMD_GK_WR = 8'he8;
	localparam logic [7:0] CMD_GK_RD = 8'he9;
	localparam logic [7:0] CMD_RT_RD = 8'h4d;
	localparam logic [7:0] CMD_RT_RD_CLR = 8'h4f;
	localparam logic [7:0] CMD_MASK_WR = 8'h6c;
	localparam logic [7:0] CMD_MASK_RD = 8'h6d;
	localparam int CMD_RW_BIT = 0;
	localparam int CMD_CLR_BIT = 1;
	// ========================================
	// field layout and reset values
	localparam int GK_W = 4;
	localparam int GK_LSB = 0;
	localparam logic [3:0] GK_RESET = 4'h0;
	localparam logic [3:0] GK_RSVD_READ = 4'h0;
	localparam logic [7:0] MASK_RESET = 8'hff;
	localparam int CHANNELS = 4;
	localparam int CHAN_W = 2;
	localparam int SLOT_LSB = 1;
	localparam int SLOT_W = 3;
	localparam int COEF_MAX_BYTES = 14;
	localparam int IDX_W = 4;
	localparam int RAM_AW = CHAN_W + SLOT_W + IDX_W;
	// ========================================
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
	// ========================================
	// transfer states
	typedef enum logic [5:0] {
		ST_ADDR = 6'h01,
		ST_CMD = 6'h02,
		ST_DATA = 6'h04,
		ST_FETCH = 6'h08,
		ST_LOAD = 6'h10,
		ST_SEND = 6'h20
	} gci_state_type;
endpackage

/* gci_ram_if.sv */
// interface: port bundle between the command core and its coefficient memory
`timescale 1ns/1ns
interface gci_ram_if #(
	parameter int AW = 9,
	parameter int DW = 8
);
	logic we;
	logic re;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	modport ctrl (output we, output re, output addr, output wdata, input rdata);
	modport mem (input we, input re, input addr, input wdata, output rdata);
endinterface

/* gci_coef_ram.sv */
// module: coefficient memory with registered read data
`timescale 1ns/1ns
module gci_coef_ram #(
	parameter int AW = 9,
	parameter int DW = 8
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	gci_ram_if.mem ram
);
	logic [DW-1:0] mem_q [0:(1<<AW)-1];
	logic [DW-1:0] rdata_q;

	// ========================================
	// write port
	always_ff @(posedge clk_i) begin
		if (ram.we) begin
			mem_q[ram.addr] <= ram.wdata;
		end
	end

	// ========================================
	// read port
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_q <= '0;
		end else if (ram.re) begin
			rdata_q <= mem_q[ram.addr];
		end
	end

	assign ram.rdata = rdata_q;
endmodule

/* gci_ctl_model.sv */
// controller model: sends downstream monitor bytes and takes upstream bytes
`timescale 1ns/1ns
module gci_ctl_model (
	input wire logic clk_i,
	input wire logic rx_ready_i,
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_byte_i,
	input wire logic tx_last_i,
	output logic rx_valid_o,
	output logic [7:0] rx_byte_o,
	output logic rx_last_o,
	output logic tx_ready_o
);
	initial begin
		rx_valid_o = 1'b0;
		rx_byte_o = 8'h00;
		rx_last_o = 1'b0;
		tx_ready_o = 1'b0;
	end
	// ========================================
	// downstream byte, held until taken; only a last byte is then released and its line inverted
	task automatic send(input logic [7:0] b, input logic l);
		int n;
		n = 0;
		@(negedge clk_i);
		rx_valid_o = 1'b1;
		rx_byte_o = b;
		rx_last_o = l;
		while (rx_ready_i !== 1'b1 && n < 200) begin
			@(negedge clk_i);
			n++;
		end
		@(posedge clk_i);
		if (l) begin
			@(negedge clk_i);
			rx_valid_o = 1'b0;
			rx_last_o = 1'b0;
			rx_byte_o = ~b;
		end
	endtask
	// ========================================
	// upstream byte, taken after a stall of st cycles
	task automatic recv(input int st, output logic [7:0] b, output logic l);
		int n;
		n = 0;
		@(negedge clk_i);
		while (tx_valid_i !== 1'b1 && n < 200) begin
			@(negedge clk_i);
			n++;
		end
		repeat (st) @(negedge clk_i);
		b = tx_byte_i;
		l = tx_last_i;
		tx_ready_o = 1'b1;
		@(posedge clk_i);
		@(negedge clk_i);
		tx_ready_o = 1'b0;
	endtask
endmodule

/* gci_line_event_and_coef_cmds_tb.sv */
// testbench: command block scenarios driven through the controller model
`timescale 1ns/1ns
module gci_line_event_and_coef_cmds_tb;
	logic clk_i;
	logic rst_b_i;
	logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
	logic [7:0] rx_byte, tx_byte, ci;
	logic [3:0] in_one, in_two, hook, deb;
	logic e1, coef_upd, int_b;
	int n_mismatch = 0;
	int samples_checked = 0;
	int upd_seen = 0;
	gci_cmd_core #(.MS_CYCLES(20), .COEF_MAX(14)) u_gci_cmd_core (
		.clk_i(clk_i), .rst_b_i(rst_b_i),
		.mon_rx_valid_i(rx_valid), .mon_rx_byte_i(rx_byte), .mon_rx_last_i(rx_last),
		.mon_rx_ready_o(rx_ready), .mon_tx_valid_o(tx_valid), .mon_tx_byte_o(tx_byte),
		.mon_tx_last_o(tx_last), .mon_tx_ready_i(tx_ready),
		.line_input_one_i(in_one), .line_input_two_i(in_two), .muxed_hook_bit_i(hook),
		.e1_mux_enable_i(e1), .debounce_ms_i(deb), .ci_upstream_o(ci),
		.coef_update_o(coef_upd), .int_b_o(int_b)
	);
	gci_ctl_model u_gci_ctl_model (
		.clk_i(clk_i), .rx_ready_i(rx_ready), .tx_valid_i(tx_valid),
		.tx_byte_i(tx_byte), .tx_last_i(tx_last), .rx_valid_o(rx_valid),
		.rx_byte_o(rx_byte), .rx_last_o(rx_last), .tx_ready_o(tx_ready)
	);
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (coef_upd === 1'b1) begin
			upd_seen++;
		end
	end
	// ========================================
	// compare, verdict and bus helpers
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp, input string m);
		chk8({7'h00, got}, {7'h00, exp}, m);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic wcyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic reg_wr(input logic [7:0] cmd, input logic [7:0] d);
		u_gci_ctl_model.send(8'h00, 1'b0);
		u_gci_ctl_model.send(cmd, 1'b0);
		u_gci_ctl_model.send(d, 1'b1);
	endtask
	task automatic reg_rd(input logic [7:0] cmd, input int st, output logic [7:0] b);
		logic l;
		u_gci_ctl_model.send(8'h00, 1'b0);
		u_gci_ctl_model.send(cmd, 1'b1);
		u_gci_ctl_model.recv(st, b, l);
		chk1(l, 1'b1, "single read byte last");
	endtask
	function automatic logic [7:0] rt_exp(input logic [3:0] a, input logic [3:0] b);
		for (int c = 0; c < 4; c++) begin
			rt_exp[2*c] = a[c];
			rt_exp[2*c+1] = b[c];
		end
	endfunction
	// ========================================
	// scenarios
	task automatic t_reset();
		logic [7:0] b;
		chk1(int_b, 1'b1, "int idle");
		reg_rd(8'he9, 0, b);
		chk8({4'h0, b[3:0]}, 8'h00, "interval reset");
		reg_rd(8'h6d, 2, b);
		chk8(b, 8'hff, "mask reset");
		$display("test reset done");
	endtask
	task automatic t_interval();
		logic [7:0] b;
		reg_wr(8'he8, 8'h0f);
		in_two[3] = 1'b1;
		wcyc(20);
		chk1(ci[7], 1'b0, "second bit held between samples");
		reg_rd(8'he9, 1, b);
		chk8({4'h0, b[3:0]}, 8'h0f, "interval max");
		reg_wr(8'he8, 8'h00);
		reg_rd(8'he9, 0, b);
		chk8({4'h0, b[3:0]}, 8'h00, "interval zero");
		chk1(ci[7], 1'b1, "second bit sampled");
		$display("test interval done");
	endtask
	task automatic t_line();
		logic [7:0] b;
		in_one = 4'b0101;
		in_two = 4'b0011;
		wcyc(10);
		reg_rd(8'h4d, 0, b);
		chk8(b, rt_exp(in_one, in_two), "line bits");
		chk8(ci, rt_exp(in_one, in_two), "ci copy");
		e1 = 1'b1;
		hook = 4'b1100;
		wcyc(10);
		reg_rd(8'h4d, 1, b);
		chk8(b, rt_exp(in_one, hook), "muxed bits");
		chk8(ci, rt_exp(in_one, hook), "ci muxed");
		chk1(int_b, 1'b1, "masked changes");
		$display("test line done");
	endtask
	task automatic t_irq();
		logic [7:0] b;
		reg_wr(8'h6c, 8'hfe);
		reg_rd(8'h6d, 0, b);
		chk8(b, 8'hfe, "mask readback");
		in_one[1] = ~in_one[1];
		wcyc(10);
		chk1(int_b, 1'b1, "masked bit");
		in_one[0] = ~in_one[0];
		wcyc(10);
		chk1(int_b, 1'b0, "unmasked bit");
		reg_rd(8'h4d, 0, b);
		chk8(b, rt_exp(in_one, hook), "event bits");
		wcyc(10);
		chk1(int_b, 1'b0, "held low");
		reg_rd(8'h4f, 2, b);
		chk1(int_b, 1'b1, "cleared");
		$display("test interrupt done");
	endtask
	task automatic t_debounce();
		deb = 4'h3;
		in_one[2] = 1'b0;
		wcyc(20);
		chk1(ci[4], 1'b1, "debounce early");
		wcyc(80);
		chk1(ci[4], 1'b0, "debounce late");
		deb = 4'h0;
		$display("test debounce done");
	endtask
	task automatic t_coef();
		logic [7:0] b;
		logic l;
		logic [7:0] rc [2] = '{8'h81, 8'h91};
		u_gci_ctl_model.send(8'h01, 1'b0);
		u_gci_ctl_model.send(8'h80, 1'b0);
		for (int i = 0; i < 14; i++) begin
			u_gci_ctl_model.send(8'h30 + 8'(i), i == 13);
		end
		wcyc(3);
		chk8(8'(upd_seen), 8'h01, "update pulse");
		for (int k = 0; k < 2; k++) begin
			u_gci_ctl_model.send(8'h01, 1'b0);
			u_gci_ctl_model.send(rc[k], 1'b1);
			for (int i = 0; i < 14; i++) begin
				u_gci_ctl_model.recv(i % 3, b, l);
				chk8(b, 8'h30 + 8'(i), "coef byte");
				chk1(l, i == 13, "coef last");
			end
		end
		$display("test coefficient done");
	endtask
	initial begin
		rst_b_i = 1'b0;
		e1 = 1'b0;
		in_one = 4'h0;
		in_two = 4'h0;
		hook = 4'h0;
		deb = 4'h0;
		repeat (5) @(negedge clk_i);
		rst_b_i = 1'b1;
		t_reset();
		t_interval();
		t_line();
		t_irq();
		t_debounce();
		t_coef();
		test_done();
	end
	initial begin
		#200000;
		n_mismatch++;
		$display("unexpected at %0t: watchdog expired", $time);
		test_done();
	end
endmodule
